// >>> hsp_pkg.sv
/*
 package of the handshake parallel port: register map, field positions,
 reset values and the internal register-bus carriers.
 assumes nothing of its surroundings.
*/
`default_nettype none
package hsp_pkg;

    // byte addresses of the register words
    localparam logic [7:0] HSP_OFF_DATA = 8'h00;
    localparam logic [7:0] HSP_OFF_CSR = 8'h04;
    localparam logic [7:0] HSP_OFF_IRQ_STS = 8'h08;
    localparam logic [7:0] HSP_OFF_IRQ_MASK = 8'h0C;

    // port_handshake_control_status fields
    localparam int HSP_CSR_INPUT_BUFFER_FULL = 0;
    localparam int HSP_CSR_OUTPUT_BUFFER_FULL = 1;
    localparam int HSP_CSR_INPUT_STROBE_MODE = 2;
    localparam int HSP_CSR_OUT_FULL_CLEAR_SELECT = 3;
    localparam int HSP_CSR_FLAG_A_MODE_LOW = 4;
    localparam int HSP_CSR_FLAG_A_MODE_HIGH = 5;
    localparam int HSP_CSR_FLAG_B_MODE_LOW = 6;
    localparam int HSP_CSR_FLAG_B_MODE_HIGH = 7;
    localparam int HSP_CSR_W = 8;

    // interrupt status and mask fields
    localparam int HSP_IRQ_INPUT_STROBE = 0;
    localparam int HSP_IRQ_OUTPUT_ACK = 1;
    localparam int HSP_IRQ_W = 2;

    // values after reset
    localparam logic [7:0] HSP_CSR_RESET = 8'h00;
    localparam logic [1:0] HSP_IRQ_MASK_RESET = 2'h0;

    // axi responses
    localparam logic [1:0] HSP_RESP_OKAY = 2'h0;
    localparam logic [1:0] HSP_RESP_SLVERR = 2'h2;

    // internal register bus
    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } hsp_wr_t;

    typedef struct packed {
        logic valid;
        logic [7:0] addr;
    } hsp_rd_t;

    typedef struct packed {
        logic [31:0] data;
        logic err;
    } hsp_rsp_t;

    // word-aligned address that hits one of the registers
    function automatic logic hsp_reg_hit(input logic [7:0] addr);
        hsp_reg_hit = (addr == HSP_OFF_DATA) || (addr == HSP_OFF_CSR) ||
                      (addr == HSP_OFF_IRQ_STS) || (addr == HSP_OFF_IRQ_MASK);
    endfunction

endpackage
`default_nettype wire

// >>> hsp_edge.sv
/*
 edge detector for a group of synchronous strobe inputs.
 assumes the inputs are already synchronous to aclk.
*/
`default_nettype none
module hsp_edge #(
    parameter int W = 2
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // levels in
    input wire logic [W-1:0] lvl,
    // one-cycle edge pulses out
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] prev_q;
    logic [W-1:0] prev_d;

    // idle strobes are high, so reset to high avoids a false edge
    always_comb begin
        prev_d = lvl;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_q <= '1;
        end else begin
            prev_q <= prev_d;
        end
    end

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_edge
            assign rise[i] = lvl[i] & ~prev_q[i];
            assign fall[i] = ~lvl[i] & prev_q[i];
        end
    endgenerate
endmodule // hsp_edge
`default_nettype wire

// >>> hsp_axil.sv
/*
 axi4-lite slave front end: turns bus transfers into single-cycle
 read and write requests on the internal register bus.
 assumes the register file answers a read in the same cycle.
*/
`default_nettype none
module hsp_axil
    import hsp_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address and data
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    // write response
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // read address and data
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // register side
    output hsp_wr_t wr,
    output hsp_rd_t rd,
    input wire hsp_rsp_t rd_rsp,
    input wire logic wr_err
);
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;

    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        wr = '0;
        rd = '0;
        // address and data are taken in either order
        if (s_awvalid && awready_q) begin
            aw_have_d = 1'b1;
            awaddr_d = s_awaddr;
        end
        if (s_wvalid && wready_q) begin
            w_have_d = 1'b1;
            wdata_d = s_wdata;
            wstrb_d = s_wstrb;
        end
        if (s_bvalid && s_bready) begin
            bvalid_d = 1'b0;
        end
        if (aw_have_q && w_have_q && !bvalid_q) begin
            wr = '{valid: 1'b1, addr: awaddr_q, data: wdata_q, strb: wstrb_q};
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = wr_err ? HSP_RESP_SLVERR : HSP_RESP_OKAY;
        end
        if (s_rvalid && s_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_arvalid && arready_q) begin
            rd = '{valid: 1'b1, addr: s_araddr};
            rvalid_d = 1'b1;
            rdata_d = rd_rsp.data;
            rresp_d = rd_rsp.err ? HSP_RESP_SLVERR : HSP_RESP_OKAY;
        end
        awready_d = !aw_have_d && !bvalid_d;
        wready_d = !w_have_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= HSP_RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= HSP_RESP_OKAY;
            rdata_q <= '0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            arready_q <= 1'b0;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            arready_q <= arready_d;
        end
    end

    assign s_awready = awready_q;
    assign s_wready = wready_q;
    assign s_bvalid = bvalid_q;
    assign s_bresp = bresp_q;
    assign s_arready = arready_q;
    assign s_rvalid = rvalid_q;
    assign s_rresp = rresp_q;
    assign s_rdata = rdata_q;
endmodule // hsp_axil
`default_nettype wire

// >>> hsp_port.sv
/*
 handshaked parallel port: data pins with input and output latches,
 two buffer-full flags, two strobe inputs and two flag outputs,
 control/status, interrupt status and mask registers over axi4-lite.
 assumes strobes and pins are synchronous to aclk.
*/
`default_nettype none
module hsp_port
    import hsp_pkg::*;
#(
    parameter int PORT_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // parallel data pins
    input wire logic [PORT_W-1:0] port_data_in,
    output logic [PORT_W-1:0] port_data_out,
    output logic port_data_oe,
    // handshake lines
    input wire logic input_data_strobe_n,
    input wire logic output_data_strobe_n,
    output logic flag_out_a,
    output logic flag_out_b,
    // interrupt
    output logic irq
);
    generate
        if (PORT_W < 1 || PORT_W > 8) begin : g_bad_width
            $error("PORT_W must lie between 1 and 8");
        end
    endgenerate

    hsp_wr_t wr;
    hsp_rd_t rd;
    hsp_rsp_t rd_rsp;
    logic wr_err;
    logic [1:0] strobe_rise, strobe_fall;

    hsp_axil u_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid),
        .s_awready(s_awready),
        .s_wdata(s_wdata),
        .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid),
        .s_wready(s_wready),
        .s_bresp(s_bresp),
        .s_bvalid(s_bvalid),
        .s_bready(s_bready),
        .s_araddr(s_araddr),
        .s_arvalid(s_arvalid),
        .s_arready(s_arready),
        .s_rdata(s_rdata),
        .s_rresp(s_rresp),
        .s_rvalid(s_rvalid),
        .s_rready(s_rready),
        .wr(wr),
        .rd(rd),
        .rd_rsp(rd_rsp),
        .wr_err(wr_err)
    );

    // bit 0 input strobe, bit 1 output strobe
    hsp_edge #(.W(2)) u_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .lvl({output_data_strobe_n, input_data_strobe_n}),
        .rise(strobe_rise),
        .fall(strobe_fall)
    );

    // flag source: low half selected gives the mode-low bit itself, else the full flag or its inverse
    function automatic logic hsp_flag_sel(input logic mode_high, input logic mode_low, input logic full);
        if (!mode_high) begin
            hsp_flag_sel = mode_low;
        end else begin
            hsp_flag_sel = mode_low ? ~full : full;
        end
    endfunction

    logic [7:2] mode_q, mode_d;
    logic ibf_q, ibf_d, obf_q, obf_d;
    logic [PORT_W-1:0] in_latch_q, in_latch_d, out_latch_q, out_latch_d;
    logic [HSP_IRQ_W-1:0] sts_q, sts_d, mask_q, mask_d;
    logic flag_a_q, flag_a_d, flag_b_q, flag_b_d, oe_q, oe_d, irq_q, irq_d;
    logic bidir, in_evt, ack_evt, wr_lane0;
    logic [7:0] csr_view;

    always_comb begin
        mode_d = mode_q;
        ibf_d = ibf_q;
        obf_d = obf_q;
        in_latch_d = in_latch_q;
        out_latch_d = out_latch_q;
        sts_d = sts_q;
        mask_d = mask_q;
        wr_lane0 = wr.valid && wr.strb[0];
        // output-only when flag-a mode high is set; otherwise bidirectional
        bidir = !mode_q[HSP_CSR_FLAG_A_MODE_HIGH];
        in_evt = mode_q[HSP_CSR_INPUT_STROBE_MODE] ? strobe_fall[0] : strobe_rise[0];
        // in bidirectional mode the output strobe only gates the drivers
        ack_evt = !bidir && (mode_q[HSP_CSR_OUT_FULL_CLEAR_SELECT] ? strobe_rise[1] : strobe_fall[1]);

        // clears first, so a set in the same cycle wins
        if (rd.valid && rd.addr == HSP_OFF_DATA) begin
            ibf_d = 1'b0;
        end
        if (ack_evt) begin
            obf_d = 1'b0;
        end
        if (wr_lane0 && wr.addr == HSP_OFF_DATA) begin
            out_latch_d = wr.data[PORT_W-1:0];
            obf_d = 1'b1;
        end
        if (wr_lane0 && wr.addr == HSP_OFF_CSR) begin
            mode_d = wr.data[7:2];
        end
        if (in_evt) begin
            ibf_d = 1'b1;
            if (bidir) begin
                in_latch_d = port_data_in;
            end
        end

        if (wr_lane0 && wr.addr == HSP_OFF_IRQ_STS) begin
            sts_d = sts_d & ~wr.data[HSP_IRQ_W-1:0];
        end
        if (wr_lane0 && wr.addr == HSP_OFF_IRQ_MASK) begin
            mask_d = wr.data[HSP_IRQ_W-1:0];
        end
        sts_d[HSP_IRQ_INPUT_STROBE] = sts_d[HSP_IRQ_INPUT_STROBE] | in_evt;
        sts_d[HSP_IRQ_OUTPUT_ACK] = sts_d[HSP_IRQ_OUTPUT_ACK] | (ack_evt & obf_q);

        flag_a_d = hsp_flag_sel(mode_d[HSP_CSR_FLAG_A_MODE_HIGH], mode_d[HSP_CSR_FLAG_A_MODE_LOW], obf_d);
        flag_b_d = hsp_flag_sel(mode_d[HSP_CSR_FLAG_B_MODE_HIGH], mode_d[HSP_CSR_FLAG_B_MODE_LOW], ibf_d);
        // a grounded output strobe leaves the drivers on permanently
        oe_d = mode_d[HSP_CSR_FLAG_A_MODE_HIGH] ? 1'b1 : !output_data_strobe_n;
        irq_d = |(sts_d & mask_d);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= HSP_CSR_RESET[7:2];
            ibf_q <= HSP_CSR_RESET[HSP_CSR_INPUT_BUFFER_FULL];
            obf_q <= HSP_CSR_RESET[HSP_CSR_OUTPUT_BUFFER_FULL];
            in_latch_q <= '0;
            out_latch_q <= '0;
            sts_q <= '0;
            mask_q <= HSP_IRQ_MASK_RESET;
            flag_a_q <= 1'b0;
            flag_b_q <= 1'b0;
            oe_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            ibf_q <= ibf_d;
            obf_q <= obf_d;
            in_latch_q <= in_latch_d;
            out_latch_q <= out_latch_d;
            sts_q <= sts_d;
            mask_q <= mask_d;
            flag_a_q <= flag_a_d;
            flag_b_q <= flag_b_d;
            oe_q <= oe_d;
            irq_q <= irq_d;
        end
    end

    // read mux; the full flags are read-only
    always_comb begin
        csr_view = {mode_q, obf_q, ibf_q};
        rd_rsp.err = !hsp_reg_hit(rd.addr);
        rd_rsp.data = 32'h0000_0000;
        unique case (rd.addr)
            HSP_OFF_DATA: rd_rsp.data[PORT_W-1:0] = in_latch_q;
            HSP_OFF_CSR: rd_rsp.data[HSP_CSR_W-1:0] = csr_view;
            HSP_OFF_IRQ_STS: rd_rsp.data[HSP_IRQ_W-1:0] = sts_q;
            HSP_OFF_IRQ_MASK: rd_rsp.data[HSP_IRQ_W-1:0] = mask_q;
            default: rd_rsp.data = 32'h0000_0000;
        endcase
        wr_err = !hsp_reg_hit(wr.addr);
    end

    assign port_data_out = out_latch_q;
    assign port_data_oe = oe_q;
    assign flag_out_a = flag_a_q;
    assign flag_out_b = flag_b_q;
    assign irq = irq_q;
endmodule // hsp_port
`default_nettype wire

// >>> hsp_port_unused_guard.sv
/*
 intentionally empty unit: holds no logic.
 assumes nothing.
*/

// >>> hsp_port_monitor.sv
/*
 checker for hsp_port: bus handshakes, answers and driver enable.
 bound from the bench top file; sees only top-level ports.
*/
`default_nettype none
module hsp_port_monitor
    import hsp_pkg::*;
#(
    parameter int PORT_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write channels
    input wire logic s_awvalid,
    input wire logic s_awready,
    input wire logic s_wvalid,
    input wire logic s_wready,
    input wire logic [1:0] s_bresp,
    input wire logic s_bvalid,
    input wire logic s_bready,
    // read channels
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic [31:0] s_rdata,
    input wire logic [1:0] s_rresp,
    input wire logic s_rvalid,
    input wire logic s_rready,
    // pins
    input wire logic output_data_strobe_n,
    input wire logic port_data_oe
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_bvalid_stands: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
        else $error("write response dropped before bready");
    a_rvalid_stands: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata) && $stable(s_rresp))
        else $error("read data dropped before rready");
    a_write_refused: assert property (s_bvalid |-> !s_awready && !s_wready)
        else $error("write taken while response pending");
    a_read_refused: assert property (s_rvalid |-> !s_arready)
        else $error("read taken while data pending");
    a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
        else $error("read not answered next cycle");
    a_write_answer: assert property (s_awvalid && s_awready && s_wvalid && s_wready |-> ##[1:2] s_bvalid)
        else $error("write not answered in time");
    a_read_unmapped: assert property (s_arvalid && s_arready && !hsp_reg_hit(s_araddr) |=> s_rresp == HSP_RESP_SLVERR)
        else $error("unmapped read not refused");
    a_read_mapped: assert property (s_arvalid && s_arready && hsp_reg_hit(s_araddr) |=> s_rresp == HSP_RESP_OKAY)
        else $error("mapped read refused");
    a_drivers_on: assert property (!output_data_strobe_n [*3] |-> port_data_oe)
        else $error("drivers off while output strobe low");
endmodule // hsp_port_monitor
`default_nettype wire

// >>> hsp_host_model.sv
/*
 far-side model: host printer port or printer driving the strobes and data.
 assumes the bench calls its tasks from one process at a time.
*/
`default_nettype none
module hsp_host_model #(
    parameter int PORT_W = 8
) (
    // clock and busy from the port
    input wire logic aclk,
    input wire logic busy,
    // lines driven toward the port
    output logic ids_n,
    output logic ods_n,
    output logic [PORT_W-1:0] data
);
    initial begin
        ids_n = 1'b1;
        ods_n = 1'b1;
        data = '0;
    end
    // honour=0 only where flag b is held at a fixed level, not a busy line
    task automatic strobe_fall(input logic [PORT_W-1:0] d, input logic honour);
        // a busy line stuck high is left to the bench watchdog
        while (honour && busy !== 1'b0) begin
            @(posedge aclk);
        end
        @(posedge aclk);
        data <= d;
        ids_n <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask
    task automatic strobe_rise();
        ids_n <= 1'b1;
        @(posedge aclk);
        // data held through the rising edge, then released: no pull, so invert
        data <= ~data;
    endtask
    task automatic ack(input logic lvl);
        @(posedge aclk);
        ods_n <= lvl;
    endtask
endmodule // hsp_host_model
`default_nettype wire

// >>> hsp_port_bench.sv
/*
 self-checking bench of hsp_port: axi4-lite master tasks and scenarios.
 assumes hsp_host_model on the pins and the monitor bound below.
*/
`default_nettype none
module hsp_port_bench;
    import hsp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PORT_W = 8;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_awaddr = '0, s_araddr = '0;
    logic [31:0] s_wdata = '0;
    logic [3:0] s_wstrb = 4'hF;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, port_data_oe, irq;
    logic [1:0] s_bresp, s_rresp;
    logic [31:0] s_rdata;
    logic [PORT_W-1:0] port_data_in, port_data_out;
    logic ids_n, ods_n, flag_out_a, flag_out_b;
    int n_mismatch = 0, cmp_count = 0;
    always #25 aclk = ~aclk;

    hsp_port #(.PORT_W(PORT_W)) dut_u (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
        .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
        .s_rready(s_rready), .port_data_in(port_data_in), .port_data_out(port_data_out),
        .port_data_oe(port_data_oe), .input_data_strobe_n(ids_n), .output_data_strobe_n(ods_n),
        .flag_out_a(flag_out_a), .flag_out_b(flag_out_b), .irq(irq));
    hsp_host_model #(.PORT_W(PORT_W)) host_u (.aclk(aclk), .busy(flag_out_b), .ids_n(ids_n), .ods_n(ods_n),
        .data(port_data_in));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // bready/rready rise only after valid is seen, so the standing rules get exercised
    // no cycle count is assumed: only the watchdog ends a wait
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        aw = 1'b0;
        w = 1'b0;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (!aw && s_awready === 1'b1) begin
                aw = 1'b1;
                s_awvalid <= 1'b0;
            end
            if (!w && s_wready === 1'b1) begin
                w = 1'b1;
                s_wvalid <= 1'b0;
            end
        end
        while (s_bvalid !== 1'b1) begin
            @(posedge aclk);
        end
        s_bready <= 1'b1;
        @(posedge aclk);
        chk("bresp", {30'h0, er}, {30'h0, s_bresp});
        s_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
        end while (s_arready !== 1'b1);
        s_arvalid <= 1'b0;
        while (s_rvalid !== 1'b1) begin
            @(posedge aclk);
        end
        s_rready <= 1'b1;
        @(posedge aclk);
        chk("rdata", ed, s_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_rresp});
        s_rready <= 1'b0;
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic t_reset();
        rd(HSP_OFF_CSR, 32'h0000_0000, HSP_RESP_OKAY);
        rd(HSP_OFF_IRQ_MASK, 32'h0000_0000, HSP_RESP_OKAY);
        chk("flags oe irq", 32'h0000_0000, {28'h0, flag_out_a, flag_out_b, port_data_oe, irq});
        $display("test reset done");
    endtask
    task automatic t_receive();
        wr(HSP_OFF_CSR, 32'h0000_0080, HSP_RESP_OKAY);
        wait_clk(3);
        chk("flag_a", 32'h0000_0000, {31'h0, flag_out_a});
        wr(HSP_OFF_CSR, 32'h0000_0090, HSP_RESP_OKAY);
        wait_clk(3);
        chk("flag_a", 32'h0000_0001, {31'h0, flag_out_a});
        host_u.strobe_fall(8'hA5, 1'b1);
        rd(HSP_OFF_CSR, 32'h0000_0090, HSP_RESP_OKAY);
        host_u.strobe_rise();
        wait_clk(3);
        rd(HSP_OFF_CSR, 32'h0000_0091, HSP_RESP_OKAY);
        chk("flag_b", 32'h0000_0001, {31'h0, flag_out_b});
        chk("irq", 32'h0000_0000, {31'h0, irq});
        wr(HSP_OFF_IRQ_MASK, 32'h0000_0003, HSP_RESP_OKAY);
        wait_clk(3);
        chk("irq", 32'h0000_0001, {31'h0, irq});
        rd(HSP_OFF_DATA, 32'h0000_00A5, HSP_RESP_OKAY);
        wait_clk(3);
        chk("flag_b", 32'h0000_0000, {31'h0, flag_out_b});
        wr(HSP_OFF_IRQ_STS, 32'h0000_0001, HSP_RESP_OKAY);
        wait_clk(3);
        chk("irq", 32'h0000_0000, {31'h0, irq});
        $display("test receive done");
    endtask
    task automatic t_bidir();
        wr(HSP_OFF_DATA, 32'h0000_005A, HSP_RESP_OKAY);
        wait_clk(3);
        chk("data_out", 32'h0000_005A, {24'h0, port_data_out});
        chk("oe", 32'h0000_0000, {31'h0, port_data_oe});
        host_u.ack(1'b0);
        wait_clk(5);
        chk("oe", 32'h0000_0001, {31'h0, port_data_oe});
        host_u.ack(1'b1);
        wait_clk(4);
        chk("oe", 32'h0000_0000, {31'h0, port_data_oe});
        rd(HSP_OFF_CSR, 32'h0000_0092, HSP_RESP_OKAY);
        rd(HSP_OFF_IRQ_STS, 32'h0000_0000, HSP_RESP_OKAY);
        $display("test bidir done");
    endtask
    task automatic t_transmit();
        wr(HSP_OFF_CSR, 32'h0000_006C, HSP_RESP_OKAY);
        wait_clk(3);
        chk("flag_b", 32'h0000_0001, {31'h0, flag_out_b});
        chk("flag_a", 32'h0000_0001, {31'h0, flag_out_a});
        chk("oe", 32'h0000_0001, {31'h0, port_data_oe});
        host_u.ack(1'b0);
        wait_clk(4);
        rd(HSP_OFF_CSR, 32'h0000_006E, HSP_RESP_OKAY);
        host_u.ack(1'b1);
        wait_clk(4);
        rd(HSP_OFF_CSR, 32'h0000_006C, HSP_RESP_OKAY);
        chk("flag_a", 32'h0000_0000, {31'h0, flag_out_a});
        chk("irq", 32'h0000_0001, {31'h0, irq});
        wr(HSP_OFF_DATA, 32'h0000_00C3, HSP_RESP_OKAY);
        wait_clk(3);
        chk("flag_a", 32'h0000_0001, {31'h0, flag_out_a});
        // flag b is held high here by its mode-low bit, so the host does not wait on it
        host_u.strobe_fall(8'h77, 1'b0);
        rd(HSP_OFF_CSR, 32'h0000_006F, HSP_RESP_OKAY);
        host_u.strobe_rise();
        rd(HSP_OFF_DATA, 32'h0000_00A5, HSP_RESP_OKAY);
        $display("test transmit done");
    endtask
    // inverted flag modes and the falling-edge acknowledge, left untouched by the tests above
    task automatic t_inverted();
        wr(HSP_OFF_CSR, 32'h0000_00F0, HSP_RESP_OKAY);
        wait_clk(3);
        chk("flag_a", 32'h0000_0000, {31'h0, flag_out_a});
        chk("flag_b", 32'h0000_0001, {31'h0, flag_out_b});
        host_u.ack(1'b0);
        wait_clk(4);
        rd(HSP_OFF_CSR, 32'h0000_00F0, HSP_RESP_OKAY);
        chk("flag_a", 32'h0000_0001, {31'h0, flag_out_a});
        host_u.ack(1'b1);
        wr(HSP_OFF_IRQ_STS, 32'h0000_0003, HSP_RESP_OKAY);
        wait_clk(3);
        chk("irq", 32'h0000_0000, {31'h0, irq});
        $display("test inverted done");
    endtask
    task automatic t_unmapped();
        wr(8'h10, 32'h0000_00FF, HSP_RESP_SLVERR);
        rd(8'h10, 32'h0000_0000, HSP_RESP_SLVERR);
        $display("test unmapped done");
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        wait_clk(2);
        t_reset();
        t_receive();
        t_bidir();
        t_transmit();
        t_inverted();
        t_unmapped();
        end_of_test();
    end
endmodule // hsp_port_bench

bind hsp_port hsp_port_monitor #(.PORT_W(PORT_W)) mon_u (.aclk(aclk), .aresetn(aresetn), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .output_data_strobe_n(output_data_strobe_n),
    .port_data_oe(port_data_oe));
`default_nettype wire
